// ---- hw/gpsr_user_pins.sv ----
// user pin and scratch register group behind the sequencer data port
`timescale 1ns/1ps
`default_nettype none

module gpsr_user_pins
    import gpsr_pkg::*;
(
    input  wire logic        core_clk_in,             // system clock, 20 MHz
    input  wire logic        resetn_in,               // async reset, active low
    // io access
    input  wire logic [15:0] io_addr_in,              // io port address
    input  wire logic        io_wr_in,                // write strobe
    input  wire logic        io_rd_in,                // read strobe
    input  wire logic [7:0]  io_wdata_in,             // write data
    output logic      [7:0]  io_rdata_out,            // read data
    output logic             io_rdata_valid_out,      // read data pulse
    output logic             io_claim_out,            // read hit this group
    // straps
    input  wire logic [3:0]  memory_data_strap_lines_in, // strap levels
    // two-wire pair
    input  wire logic        serial_data_pin_in,      // data wire level
    output logic             serial_data_pin_out,     // data drive value
    output logic             serial_data_pin_oe_out,  // data pull low
    input  wire logic        serial_clock_pin_in,     // clock wire level
    output logic             serial_clock_pin_out,    // clock drive value
    output logic             serial_clock_pin_oe_out, // clock pull low
    // user pins
    input  wire logic        user_pin_a_in,           // pin a level
    output logic             user_pin_a_out,          // pin a drive value
    output logic             user_pin_a_oe_out,       // pin a pull low
    input  wire logic        user_pin_b_in,           // pin b level
    output logic             user_pin_b_out,          // pin b drive value
    output logic             user_pin_b_oe_out        // pin b pull low
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0]          index_reg;
    logic [7:0]          index_next;
    logic [7:0]          scratch_with_straps_reg;
    logic [7:0]          scratch_with_straps_next;
    logic [7:0]          scratch_two_reg;
    logic [7:0]          scratch_two_next;
    logic [7:0]          scratch_three_reg;
    logic [7:0]          scratch_three_next;
    logic [7:0]          scratch_four_reg;
    logic [7:0]          scratch_four_next;
    logic [NUM_PINS-1:0] pin_enable_reg;
    logic [NUM_PINS-1:0] pin_enable_next;
    logic [NUM_PINS-1:0] pin_drive_reg;
    logic [NUM_PINS-1:0] pin_drive_next;
    logic [7:0]          rdata_reg;
    logic [7:0]          rdata_next;
    logic                rvalid_reg;
    logic                rvalid_next;
    logic                claim_reg;
    logic                claim_next;

    logic                index_sel;
    logic                data_sel;
    logic                data_wr;
    logic [7:0]          read_value;
    logic                read_hit;
    logic [3:0]          strap_value;
    logic                strap_load;
    logic [NUM_PINS-1:0] pin_pad_in;
    logic [NUM_PINS-1:0] pin_pad_out;
    logic [NUM_PINS-1:0] pin_pad_oe;
    logic [NUM_PINS-1:0] pin_level;
    logic [7:0]          two_wire_view;
    logic [7:0]          user_view;

    // ------------------------------------------------------------
    // port decode
    // ------------------------------------------------------------

    // the index port picks the register, the data port moves the data
    always_comb begin
        index_sel = 1'b0;
        data_sel  = 1'b0;
        if (io_addr_in == SEQ_INDEX_PORT) begin
            index_sel = 1'b1;
        end else if (io_addr_in == SEQ_DATA_PORT) begin
            data_sel = 1'b1;
        end
    end

    assign data_wr = io_wr_in & data_sel;

    // ------------------------------------------------------------
    // index register
    // ------------------------------------------------------------

    // holds the selected register index until rewritten
    always_comb begin
        index_next = index_reg;
        if (io_wr_in && index_sel) begin
            index_next = io_wdata_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            index_reg <= INDEX_RESET;
        end else begin
            index_reg <= index_next;
        end
    end

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------

    // loads the low scratch nibble once after reset release
    gpsr_strap_capture u_strap (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .strap_in    (memory_data_strap_lines_in),
        .strap_out   (strap_value),
        .load_out    (strap_load)
    );

    // ------------------------------------------------------------
    // scratch registers
    // ------------------------------------------------------------

    // upper nibble plain storage, lower nibble also takes straps
    always_comb begin
        scratch_with_straps_next = scratch_with_straps_reg;
        if (data_wr && (index_reg == IDX_SCRATCH_WITH_STRAPS)) begin
            scratch_with_straps_next = io_wdata_in;
        end
        if (strap_load) begin
            scratch_with_straps_next[STRAP_MSB:0] = strap_value;
        end
    end

    // three plain eight-bit scratch registers
    always_comb begin
        scratch_two_next   = scratch_two_reg;
        scratch_three_next = scratch_three_reg;
        scratch_four_next  = scratch_four_reg;
        if (data_wr) begin
            if (index_reg == IDX_SCRATCH_TWO) begin
                scratch_two_next = io_wdata_in;
            end else if (index_reg == IDX_SCRATCH_THREE) begin
                scratch_three_next = io_wdata_in;
            end else if (index_reg == IDX_SCRATCH_FOUR) begin
                scratch_four_next = io_wdata_in;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scratch_with_straps_reg <= SCRATCH_RESET;
            scratch_two_reg         <= SCRATCH_RESET;
            scratch_three_reg       <= SCRATCH_RESET;
            scratch_four_reg        <= SCRATCH_RESET;
        end else begin
            scratch_with_straps_reg <= scratch_with_straps_next;
            scratch_two_reg         <= scratch_two_next;
            scratch_three_reg       <= scratch_three_next;
            scratch_four_reg        <= scratch_four_next;
        end
    end

    // ------------------------------------------------------------
    // pin control registers
    // ------------------------------------------------------------

    // only enable and drive bits are stored; level and reserved dropped
    always_comb begin
        pin_enable_next = pin_enable_reg;
        pin_drive_next  = pin_drive_reg;
        if (data_wr) begin
            if (index_reg == IDX_TWO_WIRE_PIN_CONTROL) begin
                pin_enable_next[PIN_DATA]  = io_wdata_in[BIT_HIGH_ENABLE];
                pin_enable_next[PIN_CLOCK] = io_wdata_in[BIT_LOW_ENABLE];
                pin_drive_next[PIN_DATA]   = io_wdata_in[BIT_HIGH_DRIVE];
                pin_drive_next[PIN_CLOCK]  = io_wdata_in[BIT_LOW_DRIVE];
            end else if (index_reg == IDX_USER_PIN_CONTROL) begin
                pin_enable_next[PIN_USR_B] = io_wdata_in[BIT_HIGH_ENABLE];
                pin_enable_next[PIN_USR_A] = io_wdata_in[BIT_LOW_ENABLE];
                pin_drive_next[PIN_USR_B]  = io_wdata_in[BIT_HIGH_DRIVE];
                pin_drive_next[PIN_USR_A]  = io_wdata_in[BIT_LOW_DRIVE];
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_enable_reg <= '0;
            pin_drive_reg  <= '0;
        end else begin
            pin_enable_reg <= pin_enable_next;
            pin_drive_reg  <= pin_drive_next;
        end
    end

    // ------------------------------------------------------------
    // open-drain pin cells
    // ------------------------------------------------------------

    assign pin_pad_in[PIN_CLOCK] = serial_clock_pin_in;
    assign pin_pad_in[PIN_DATA]  = serial_data_pin_in;
    assign pin_pad_in[PIN_USR_A] = user_pin_a_in;
    assign pin_pad_in[PIN_USR_B] = user_pin_b_in;

    // one cell per pin; a disabled pin stops pulling low one edge after its enable bit clears
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
            gpsr_od_pin u_pin (
                .core_clk_in (core_clk_in),
                .resetn_in   (resetn_in),
                .enable_in   (pin_enable_reg[gi]),
                .drive_in    (pin_drive_reg[gi]),
                .pad_in      (pin_pad_in[gi]),
                .pad_out     (pin_pad_out[gi]),
                .pad_oe_out  (pin_pad_oe[gi]),
                .level_out   (pin_level[gi])
            );
        end
    endgenerate

    assign serial_clock_pin_out    = pin_pad_out[PIN_CLOCK];
    assign serial_clock_pin_oe_out = pin_pad_oe[PIN_CLOCK];
    assign serial_data_pin_out     = pin_pad_out[PIN_DATA];
    assign serial_data_pin_oe_out  = pin_pad_oe[PIN_DATA];
    assign user_pin_a_out          = pin_pad_out[PIN_USR_A];
    assign user_pin_a_oe_out       = pin_pad_oe[PIN_USR_A];
    assign user_pin_b_out          = pin_pad_out[PIN_USR_B];
    assign user_pin_b_oe_out       = pin_pad_oe[PIN_USR_B];

    // ------------------------------------------------------------
    // read views of the pin registers
    // ------------------------------------------------------------

    // reserved bits read zero, level bits come from the wires
    always_comb begin
        two_wire_view                  = READ_ZERO;
        two_wire_view[BIT_HIGH_ENABLE] = pin_enable_reg[PIN_DATA];
        two_wire_view[BIT_LOW_ENABLE]  = pin_enable_reg[PIN_CLOCK];
        two_wire_view[BIT_HIGH_LEVEL]  = pin_level[PIN_DATA];
        two_wire_view[BIT_LOW_LEVEL]   = pin_level[PIN_CLOCK];
        two_wire_view[BIT_HIGH_DRIVE]  = pin_drive_reg[PIN_DATA];
        two_wire_view[BIT_LOW_DRIVE]   = pin_drive_reg[PIN_CLOCK];
        user_view                      = READ_ZERO;
        user_view[BIT_HIGH_ENABLE]     = pin_enable_reg[PIN_USR_B];
        user_view[BIT_LOW_ENABLE]      = pin_enable_reg[PIN_USR_A];
        user_view[BIT_HIGH_LEVEL]      = pin_level[PIN_USR_B];
        user_view[BIT_LOW_LEVEL]       = pin_level[PIN_USR_A];
        user_view[BIT_HIGH_DRIVE]      = pin_drive_reg[PIN_USR_B];
        user_view[BIT_LOW_DRIVE]       = pin_drive_reg[PIN_USR_A];
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------

    // selects the addressed register; other indices belong elsewhere
    always_comb begin
        read_value = READ_ZERO;
        read_hit   = 1'b0;
        if (index_sel) begin
            read_value = index_reg;
            read_hit   = 1'b1;
        end else if (!data_sel) begin
            read_hit = 1'b0;
        end else if (index_reg == IDX_SCRATCH_WITH_STRAPS) begin
            read_value = scratch_with_straps_reg;
            read_hit   = 1'b1;
        end else if (index_reg == IDX_SCRATCH_TWO) begin
            read_value = scratch_two_reg;
            read_hit   = 1'b1;
        end else if (index_reg == IDX_TWO_WIRE_PIN_CONTROL) begin
            read_value = two_wire_view;
            read_hit   = 1'b1;
        end else if (index_reg == IDX_USER_PIN_CONTROL) begin
            read_value = user_view;
            read_hit   = 1'b1;
        end else if (index_reg == IDX_SCRATCH_THREE) begin
            read_value = scratch_three_reg;
            read_hit   = 1'b1;
        end else if (index_reg == IDX_SCRATCH_FOUR) begin
            read_value = scratch_four_reg;
            read_hit   = 1'b1;
        end
    end

    // read data and its pulse are registered one edge after the strobe
    always_comb begin
        rdata_next  = rdata_reg;
        rvalid_next = io_rd_in;
        claim_next  = 1'b0;
        if (io_rd_in) begin
            rdata_next = read_value;
            claim_next = read_hit;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_reg  <= READ_ZERO;
            rvalid_reg <= 1'b0;
            claim_reg  <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            claim_reg  <= claim_next;
        end
    end

    assign io_rdata_out       = rdata_reg;
    assign io_rdata_valid_out = rvalid_reg;
    assign io_claim_out       = claim_reg;

endmodule

`default_nettype wire

// ---- hw/gpsr_pkg.sv ----
// package of constants for the user pin and scratch register group

package gpsr_pkg;

    // ------------------------------------------------------------
    // io ports of the sequencer
    // ------------------------------------------------------------
    localparam logic [15:0] SEQ_INDEX_PORT = 16'h03C4;
    localparam logic [15:0] SEQ_DATA_PORT  = 16'h03C5;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_SCRATCH_WITH_STRAPS  = 8'h70;
    localparam logic [7:0] IDX_SCRATCH_TWO          = 8'h71;
    localparam logic [7:0] IDX_TWO_WIRE_PIN_CONTROL = 8'h72;
    localparam logic [7:0] IDX_USER_PIN_CONTROL     = 8'h73;
    localparam logic [7:0] IDX_SCRATCH_THREE        = 8'h74;
    localparam logic [7:0] IDX_SCRATCH_FOUR         = 8'h75;

    // ------------------------------------------------------------
    // field positions, shared by both pin control registers, and the strap field
    // ------------------------------------------------------------
    localparam int unsigned BIT_HIGH_ENABLE = 5;  // data pin / user pin b
    localparam int unsigned BIT_LOW_ENABLE  = 4;  // clock pin / user pin a
    localparam int unsigned BIT_HIGH_LEVEL  = 3;
    localparam int unsigned BIT_LOW_LEVEL   = 2;
    localparam int unsigned BIT_HIGH_DRIVE  = 1;
    localparam int unsigned BIT_LOW_DRIVE   = 0;
    localparam int unsigned STRAP_MSB       = 3;
    localparam int unsigned STRAP_WIDTH     = 4;

    // ------------------------------------------------------------
    // pin numbering inside the pin array
    // ------------------------------------------------------------
    localparam int unsigned NUM_PINS  = 4;
    localparam int unsigned PIN_CLOCK = 0;
    localparam int unsigned PIN_DATA  = 1;
    localparam int unsigned PIN_USR_A = 2;
    localparam int unsigned PIN_USR_B = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PIN_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SCRATCH_RESET     = 8'h00;
    localparam logic [7:0] INDEX_RESET       = 8'h00;
    localparam logic [7:0] READ_ZERO         = 8'h00;
    localparam logic [3:0] STRAP_RESET       = 4'h0;

endpackage

// ---- hw/gpsr_od_pin.sv ----
// open-drain pin cell with registered enable and sampled level
`timescale 1ns/1ps
`default_nettype none

module gpsr_od_pin
    import gpsr_pkg::*;
(
    input  wire logic core_clk_in,   // system clock
    input  wire logic resetn_in,     // async reset, active low
    input  wire logic enable_in,     // pin enable bit
    input  wire logic drive_in,      // drive bit, 0 pulls low
    input  wire logic pad_in,        // level seen on the wire
    output logic      pad_out,       // value driven, always low
    output logic      pad_oe_out,    // high while pulling low
    output logic      level_out      // sampled wire level
);

    logic oe_reg;
    logic oe_next;
    logic level_reg;
    logic level_next;

    // pull low only when enabled and drive is zero
    always_comb begin
        oe_next    = enable_in & ~drive_in;
        level_next = pad_in;
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            oe_reg    <= 1'b0;
            level_reg <= 1'b1;
        end else begin
            oe_reg    <= oe_next;
            level_reg <= level_next;
        end
    end

    assign pad_out    = 1'b0;
    assign pad_oe_out = oe_reg;
    assign level_out  = level_reg;

endmodule

`default_nettype wire

// ---- hw/gpsr_strap_capture.sv ----
// catches the strap lines once, on the first edge after reset release
`timescale 1ns/1ps
`default_nettype none

module gpsr_strap_capture
    import gpsr_pkg::*;
(
    input  wire logic                   core_clk_in, // system clock
    input  wire logic                   resetn_in,   // async reset, active low
    input  wire logic [STRAP_WIDTH-1:0] strap_in,    // strap lines
    output logic      [STRAP_WIDTH-1:0] strap_out,   // captured straps
    output logic                        load_out     // one-cycle load pulse
);

    logic                   done_reg;
    logic                   done_next;
    logic                   load_reg;
    logic                   load_next;
    logic [STRAP_WIDTH-1:0] strap_reg;
    logic [STRAP_WIDTH-1:0] strap_next;

    // sample the lines only on the first clocked edge
    always_comb begin
        done_next  = 1'b1;
        load_next  = ~done_reg;
        strap_next = done_reg ? strap_reg : strap_in;
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_reg  <= 1'b0;
            load_reg  <= 1'b0;
            strap_reg <= STRAP_RESET;
        end else begin
            done_reg  <= done_next;
            load_reg  <= load_next;
            strap_reg <= strap_next;
        end
    end

    assign strap_out = strap_reg;
    assign load_out  = load_reg;

endmodule

`default_nettype wire

// ---- test/gpsr_pin_model.sv ----
// open-drain wires with pull-ups, shared with other parties
`timescale 1ns/1ps
`default_nettype none

module gpsr_pin_model
    import gpsr_pkg::*;
(
    input  wire logic [NUM_PINS-1:0] oe_in,      // device pulling low
    input  wire logic [NUM_PINS-1:0] out_in,     // device drive value
    input  wire logic [NUM_PINS-1:0] ext_low_in, // other party pulls low
    output logic      [NUM_PINS-1:0] level_out   // wire level
);
    // pull-up on a released line, any pulling party wins
    assign level_out = ~ext_low_in & (~oe_in | out_in);
endmodule

`default_nettype wire

// ---- test/gpsr_user_pins_chk.sv ----
// concurrent checks on the pin and scratch group ports
`timescale 1ns/1ps
`default_nettype none

module gpsr_user_pins_chk
    import gpsr_pkg::*;
(
    input wire logic        core_clk_in,             // clock
    input wire logic        resetn_in,               // reset
    input wire logic [15:0] io_addr_in,              // address
    input wire logic        io_wr_in,                // write
    input wire logic        io_rd_in,                // read
    input wire logic [7:0]  io_wdata_in,             // write data
    input wire logic [7:0]  io_rdata_out,            // read data
    input wire logic        io_rdata_valid_out,      // read pulse
    input wire logic        io_claim_out,            // hit pulse
    input wire logic        serial_data_pin_in,      // data wire
    input wire logic        serial_clock_pin_in,     // clock wire
    input wire logic        user_pin_a_in,           // pin a wire
    input wire logic        user_pin_b_in,           // pin b wire
    input wire logic        serial_data_pin_oe_out,  // data pull
    input wire logic        serial_clock_pin_oe_out, // clock pull
    input wire logic        user_pin_a_oe_out,       // pin a pull
    input wire logic        user_pin_b_oe_out        // pin b pull
);
    logic [7:0] idx_reg;
    logic [7:0] idx_next;
    logic [1:0] up_reg;
    logic [1:0] up_next;

    // index shadow and warm-up count after reset
    always_comb begin
        idx_next = idx_reg;
        up_next  = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
        if (io_wr_in && io_addr_in == SEQ_INDEX_PORT) begin
            idx_next = io_wdata_in;
        end
    end
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            idx_reg <= INDEX_RESET;
            up_reg  <= 2'h0;
        end else begin
            idx_reg <= idx_next;
            up_reg  <= up_next;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_wr(logic [7:0] idx);
        io_wr_in && io_addr_in == SEQ_DATA_PORT && idx_reg == idx;
    endsequence
    sequence s_rd(logic [7:0] idx);
        io_rd_in && io_addr_in == SEQ_DATA_PORT && idx_reg == idx && up_reg == 2'h3;
    endsequence
    property p_oe(logic [7:0] idx, int eb, int db, logic oe);
        s_wr(idx) |-> ##2 (oe == ($past(io_wdata_in[eb], 2) & ~$past(io_wdata_in[db], 2)));
    endproperty
    property p_lvl(logic [7:0] idx, logic hi, logic lo);
        s_rd(idx) |=> (io_rdata_out[7:6] == 2'h0)
            && (io_rdata_out[3:2] == {$past(hi, 2), $past(lo, 2)});
    endproperty

    chk_rd_gives_valid: assert property (io_rd_in |=> io_rdata_valid_out)
        else $error("read strobe without read pulse");
    chk_valid_needs_rd: assert property (io_rdata_valid_out |-> $past(io_rd_in))
        else $error("read pulse without read strobe");
    chk_claim_with_valid: assert property (io_claim_out |-> io_rdata_valid_out)
        else $error("claim outside read pulse");
    chk_data_pin_gate: assert property (p_oe(IDX_TWO_WIRE_PIN_CONTROL, 5, 1,
        serial_data_pin_oe_out)) else $error("data pin pull wrong");
    chk_clock_pin_gate: assert property (p_oe(IDX_TWO_WIRE_PIN_CONTROL, 4, 0,
        serial_clock_pin_oe_out)) else $error("clock pin pull wrong");
    chk_pin_b_gate: assert property (p_oe(IDX_USER_PIN_CONTROL, 5, 1,
        user_pin_b_oe_out)) else $error("pin b pull wrong");
    chk_pin_a_gate: assert property (p_oe(IDX_USER_PIN_CONTROL, 4, 0,
        user_pin_a_oe_out)) else $error("pin a pull wrong");
    chk_two_wire_level: assert property (p_lvl(IDX_TWO_WIRE_PIN_CONTROL,
        serial_data_pin_in, serial_clock_pin_in)) else $error("two-wire level wrong");
    chk_user_pin_level: assert property (p_lvl(IDX_USER_PIN_CONTROL,
        user_pin_b_in, user_pin_a_in)) else $error("user pin level wrong");
endmodule

bind gpsr_user_pins gpsr_user_pins_chk gpsr_user_pins_chk_i (
    .core_clk_in, .resetn_in, .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in,
    .io_rdata_out, .io_rdata_valid_out, .io_claim_out, .serial_data_pin_in,
    .serial_clock_pin_in, .user_pin_a_in, .user_pin_b_in, .serial_data_pin_oe_out,
    .serial_clock_pin_oe_out, .user_pin_a_oe_out, .user_pin_b_oe_out
);

`default_nettype wire

// ---- test/gpsr_user_pins_test.sv ----
// self-checking bench for the pin and scratch register group
`timescale 1ns/1ps
`default_nettype none

module gpsr_user_pins_test
    import gpsr_pkg::*;
();
    logic        core_clk_in = 1'b0;
    logic        resetn_in   = 1'b0;
    logic [15:0] io_addr_in  = 16'h0000;
    logic        io_wr_in    = 1'b0;
    logic        io_rd_in    = 1'b0;
    logic [7:0]  io_wdata_in = 8'h00;
    logic [3:0]  strap       = 4'hA;
    logic [3:0]  ext_low     = 4'h0;
    wire  [7:0]  io_rdata_out;
    wire         io_rdata_valid_out;
    wire         io_claim_out;
    wire  [3:0]  oe_v;
    wire  [3:0]  out_v;
    wire  [3:0]  lvl_v;
    int          num_errors  = 0;
    int          comparisons = 0;

    // 20 MHz clock
    always #25 core_clk_in = ~core_clk_in;

    gpsr_user_pins gpsr_user_pins_i (
        .core_clk_in, .resetn_in, .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in,
        .io_rdata_out, .io_rdata_valid_out, .io_claim_out,
        .memory_data_strap_lines_in (strap),
        .serial_data_pin_in         (lvl_v[PIN_DATA]),
        .serial_data_pin_out        (out_v[PIN_DATA]),
        .serial_data_pin_oe_out     (oe_v[PIN_DATA]),
        .serial_clock_pin_in        (lvl_v[PIN_CLOCK]),
        .serial_clock_pin_out       (out_v[PIN_CLOCK]),
        .serial_clock_pin_oe_out    (oe_v[PIN_CLOCK]),
        .user_pin_a_in              (lvl_v[PIN_USR_A]),
        .user_pin_a_out             (out_v[PIN_USR_A]),
        .user_pin_a_oe_out          (oe_v[PIN_USR_A]),
        .user_pin_b_in              (lvl_v[PIN_USR_B]),
        .user_pin_b_out             (out_v[PIN_USR_B]),
        .user_pin_b_oe_out          (oe_v[PIN_USR_B])
    );

    gpsr_pin_model gpsr_pin_model_i (
        .oe_in      (oe_v),
        .out_in     (out_v),
        .ext_low_in (ext_low),
        .level_out  (lvl_v)
    );

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // one strobe cycle, inputs moved just after the edge
    task automatic io_cycle(input logic [15:0] a, input logic wr, input logic [7:0] d);
        @(posedge core_clk_in);
        #2;
        io_addr_in  = a;
        io_wdata_in = d;
        io_wr_in    = wr;
        io_rd_in    = ~wr;
        @(posedge core_clk_in);
        #2;
        io_wr_in = 1'b0;
        io_rd_in = 1'b0;
    endtask

    task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
        io_cycle(SEQ_INDEX_PORT, 1'b1, idx);
        io_cycle(SEQ_DATA_PORT, 1'b1, d);
    endtask

    task automatic reg_read(input logic [7:0] idx, input logic [7:0] exp, input logic cl,
                            input string what);
        io_cycle(SEQ_INDEX_PORT, 1'b1, idx);
        io_cycle(SEQ_DATA_PORT, 1'b0, 8'h00);
        check8("read pulse", 8'h01, {7'h00, io_rdata_valid_out});
        check8("claim", {7'h00, cl}, {7'h00, io_claim_out});
        check8(what, exp, io_rdata_out);
    endtask

    task automatic test_straps();
        reg_read(IDX_SCRATCH_WITH_STRAPS, {SCRATCH_RESET[7:4], 4'hA}, 1'b1, "straps");
        reg_write(IDX_SCRATCH_WITH_STRAPS, 8'hC5);
        reg_read(IDX_SCRATCH_WITH_STRAPS, 8'hC5, 1'b1, "scratch one");
        $display("test_straps done");
    endtask

    task automatic test_scratch();
        logic [7:0] idx [3] = '{IDX_SCRATCH_TWO, IDX_SCRATCH_THREE, IDX_SCRATCH_FOUR};
        foreach (idx[k]) reg_write(idx[k], ~idx[k]);
        reg_write(8'h76, 8'hFF);
        foreach (idx[k]) reg_read(idx[k], ~idx[k], 1'b1, "scratch");
        reg_read(8'h76, READ_ZERO, 1'b0, "unmapped");
        $display("test_scratch done");
    endtask

    // every enable and drive pair, ignored bits written as ones
    task automatic test_pin_reg(input logic [7:0] idx, input int base);
        logic [7:0] w;
        logic       hi;
        logic       lo;
        for (int i = 0; i < 16; i++) begin
            w  = {2'b11, i[3:2], 2'b11, i[1:0]};
            hi = i[3] & ~i[1];
            lo = i[2] & ~i[0];
            reg_write(idx, w);
            repeat (2) @(posedge core_clk_in);
            #2;
            check8("pull", {6'h00, hi, lo}, {6'h00, oe_v[base+1], oe_v[base]});
            reg_read(idx, {2'b00, i[3:2], ~hi, ~lo, i[1:0]}, 1'b1, "pin reg");
        end
        $display("test_pin_reg done");
    endtask

    task automatic test_pulled_low();
        reg_write(IDX_TWO_WIRE_PIN_CONTROL, 8'h33);
        reg_write(IDX_USER_PIN_CONTROL, 8'h33);
        ext_low = 4'hF;
        reg_read(IDX_TWO_WIRE_PIN_CONTROL, 8'h33, 1'b1, "two-wire low");
        reg_read(IDX_USER_PIN_CONTROL, 8'h33, 1'b1, "user low");
        ext_low = 4'h0;
        reg_read(IDX_TWO_WIRE_PIN_CONTROL, 8'h3F, 1'b1, "two-wire free");
        $display("test_pulled_low done");
    endtask

    // overall run limit
    initial begin
        repeat (20000) @(posedge core_clk_in);
        num_errors++;
        final_report();
    end

    initial begin
        repeat (2) @(posedge core_clk_in);
        #2;
        resetn_in = 1'b1;
        repeat (3) @(posedge core_clk_in);
        strap = 4'h3;
        test_straps();
        test_scratch();
        test_pin_reg(IDX_TWO_WIRE_PIN_CONTROL, PIN_CLOCK);
        test_pin_reg(IDX_USER_PIN_CONTROL, PIN_USR_A);
        test_pulled_low();
        final_report();
    end
endmodule

`default_nettype wire
